// >>> include/ibm_params.svh
// Constants for the bus master command and drive timing block
`ifndef IBM_PARAMS_SVH
`define IBM_PARAMS_SVH

// ----------------------------------------
// I/O block layout
// ----------------------------------------
`define IBM_BLOCK_BYTES      16
`define IBM_OFS_PRI_CMD      4'h0
`define IBM_OFS_SEC_CMD      4'h8
`define IBM_CMD_RESET        8'h00

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define IBM_BIT_RUN          0
`define IBM_BIT_DIR          3
`define IBM_CMD_WMASK        8'h09

// ----------------------------------------
// Compatible timing, in host clocks
// ----------------------------------------
`define IBM_COMPAT_SAMPLE    4'h5
`define IBM_COMPAT_RECOVERY  4'h4

// ----------------------------------------
// Drive timing word and slave nibble fields
// ----------------------------------------
`define IBM_TW_SEP_EN        14
`define IBM_TW_ISP_HI        13
`define IBM_TW_ISP_LO        12
`define IBM_TW_RCT_HI        9
`define IBM_TW_RCT_LO        8
`define IBM_TW_DTE_D1        7
`define IBM_TW_DTE_D0        3
`define IBM_SLV_ISP_HI       3
`define IBM_SLV_ISP_LO       2
`define IBM_SLV_RCT_HI       1
`define IBM_SLV_RCT_LO       0

`endif

// >>> include/ibm_pkg.sv
// Types for the bus master command and drive timing block
package ibm_pkg;
    typedef enum logic [1:0] {
        IBM_IDLE   = 2'b00,
        IBM_ACTIVE = 2'b01,
        IBM_DONE   = 2'b10
    } ibm_chan_state_t;
endpackage : ibm_pkg

// >>> tb/ibm_bus_master_assertions.sv
// Checker for the primary channel of the bus master command block
`timescale 1ns/1ps

module ibm_bus_master_assertions (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // Watched ports
    input wire logic [15:0] i_io_base,
    input wire logic [15:0] i_io_addr,
    input wire logic [3:0]  i_io_be,
    input wire logic        i_io_wr,
    input wire logic        i_io_rd,
    input wire logic [31:0] i_io_wdata,
    input wire logic [31:0] o_io_rdata,
    input wire logic [1:0]  i_int_clear,
    input wire logic [1:0]  i_last_region_done,
    input wire logic [1:0]  i_sync_dma_busy,
    input wire logic [1:0]  i_drive_irq,
    input wire logic [1:0]  o_run,
    input wire logic [1:0]  o_dir,
    input wire logic [1:0]  o_active,
    input wire logic [1:0]  o_int_status,
    input wire logic [1:0]  o_abort
);
    wire logic at0 = i_io_addr[15:2] == {i_io_base[15:4], 2'b00};
    wire logic wr0 = i_io_wr && i_io_be[0] && at0;
    wire logic rd0 = i_io_rd && at0;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_start; wr0 && i_io_wdata[0] && !o_run[0]; endsequence
    sequence s_stop;  wr0 && !i_io_wdata[0]; endsequence

    a_start_sets_active: assert property (s_start |=> o_active[0] && o_run[0])
        else $error("start did not raise active");
    a_stop_clears: assert property (s_stop |=> !o_active[0] && !o_run[0])
        else $error("stop did not clear run and active");
    a_stop_aborts: assert property (s_stop and (o_active[0] && !o_int_status[0])
        |=> o_abort[0] ##1 !o_abort[0])
        else $error("abort pulse missing");
    a_abort_cause: assert property (o_abort[0] |-> $past(o_active[0]) && !o_run[0])
        else $error("abort without an active stop");
    a_dir_locked: assert property (wr0 && i_sync_dma_busy[0] |=> $stable(o_dir[0]))
        else $error("direction changed during sync transfer");
    a_dir_written: assert property (wr0 && !i_sync_dma_busy[0]
        |=> o_dir[0] == $past(i_io_wdata[3]))
        else $error("direction not written");
    a_eot_clears: assert property (i_last_region_done[0] && !wr0 |=> !o_active[0])
        else $error("active kept after end of table");
    a_irq_sets: assert property ($rose(i_drive_irq[0]) |=> o_int_status[0])
        else $error("interrupt edge not latched");
    a_int_cleared: assert property (i_int_clear[0] && !i_drive_irq[0] |=> !o_int_status[0])
        else $error("interrupt status not cleared");
    a_read_cmd: assert property (rd0
        |=> o_io_rdata[7:0] == {4'h0, $past(o_dir[0]), 2'b00, $past(o_run[0])})
        else $error("command read back wrong");
endmodule : ibm_bus_master_assertions

bind ibm_bus_master ibm_bus_master_assertions u_chk (.i_clk, .i_reset, .i_io_base, .i_io_addr,
    .i_io_be, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .i_int_clear, .i_last_region_done,
    .i_sync_dma_busy, .i_drive_irq, .o_run, .o_dir, .o_active, .o_int_status, .o_abort);

// >>> tb/ibm_drive_model.sv
// Drive-side model: at most one interrupt edge and end-of-table pulse per command
`timescale 1ns/1ps

module ibm_drive_model (
    // Clock
    input  wire logic       i_clk,
    // Channel state and pace
    input  wire logic [1:0] i_active,
    input  wire logic       i_slow,
    // Drive lines
    output logic      [1:0] o_irq,
    output logic      [1:0] o_eot
);
    logic [5:0] cnt [2] = '{6'h00, 6'h00};
    logic       fire    [2];

    initial o_irq = 2'b00;
    initial o_eot = 2'b00;

    // Slow pace leaves room to stop a command before the drive finishes
    always_comb begin
        for (int c = 0; c < 2; c++) fire[c] = i_active[c] && cnt[c] == (i_slow ? 6'h28 : 6'h04);
    end

    // Plain always: the outputs also carry start values from an initial block
    always @(posedge i_clk) begin
        for (int c = 0; c < 2; c++) begin
            cnt[c]   <= i_active[c] ? cnt[c] + 6'h01 : 6'h00;
            o_irq[c] <= fire[c];
            o_eot[c] <= fire[c];
        end
    end
endmodule : ibm_drive_model

// >>> tb/testbench.sv
// Self-checking bench for the bus master command block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    localparam logic [15:0] BASE = 16'hC400;
    logic        i_clk = 0, i_reset = 1, io_wr = 0, io_rd = 0, slow = 0, hit;
    logic [15:0] io_addr = 16'h0000, w_pri = 16'h0000, w_sec = 16'h0000;
    logic [3:0]  be = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  int_clr = 0, busy = 0, sel = 0, dmac = 0, irq, eot, run, dir, act, ints, abt;
    logic [7:0]  slv = 8'h00, smp, rcv;
    logic [19:0] rows [8] = '{20'hC0054, 20'h80054, 20'hD0444, 20'h90444,
                              20'hE1933, 20'hA1933, 20'hE3B31, 20'hA3B31};
    int          bad_count = 0, n_tests = 0;

    always #12.5 i_clk = ~i_clk;

    ibm_bus_master dut (.i_clk, .i_reset, .i_io_base(BASE), .i_io_addr(io_addr), .i_io_be(be),
        .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_hit(hit),
        .i_int_clear(int_clr), .i_last_region_done(eot), .i_sync_dma_busy(busy), .i_drive_irq(irq),
        .i_drive_sel(sel), .i_dma_cycle(dmac), .i_timing_word_pri(w_pri), .i_timing_word_sec(w_sec),
        .i_slave_timing_byte(slv), .o_run(run), .o_dir(dir), .o_active(act), .o_int_status(ints),
        .o_abort(abt), .o_sample(smp), .o_recovery(rcv));

    ibm_drive_model u_drv (.i_clk, .i_active(act), .i_slow(slow), .o_irq(irq), .o_eot(eot));

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        io_addr = BASE + {12'h000, ofs};
        wdata = {24'h0, d};
        io_wr = 1;
        tick(1);
        io_wr = 0;
    endtask : wr

    task automatic rd(input logic [3:0] ofs, input logic [31:0] e);
        io_addr = BASE + {12'h000, ofs};
        io_rd = 1;
        tick(1);
        io_rd = 0;
        `CHK(rdata, e)
    endtask : rd

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial begin
        tick(5);
        i_reset = 0;
        `CHK(smp, 8'h55)
        `CHK(rcv, 8'h44)
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h0);
        // ----------------------------------------
        // Timing presets, master and slave drive
        // ----------------------------------------
        foreach (rows[k]) begin
            w_pri = {rows[k][19:12], 8'h00};
            w_sec = w_pri;
            slv = {2{rows[k][11:8]}};
            for (int d = 0; d < 2; d++) begin
                sel = {2{d[0]}};
                tick(2);
                `CHK(smp, {2{rows[k][7:4]}})
                `CHK(rcv, {2{rows[k][3:0]}})
            end
        end
        // DMA-only option keeps compatible timing outside DMA cycles, each drive
        w_pri = 16'hE308;
        sel = 0;
        tick(2);
        `CHK(smp[3:0], 4'h5)
        dmac = 2'b11;
        tick(2);
        `CHK(rcv[3:0], 4'h1)
        w_pri = 16'hE380;
        sel = 2'b01;
        dmac = 0;
        tick(2);
        `CHK(rcv[3:0], 4'h4)
        dmac = 2'b11;
        tick(2);
        `CHK(rcv[3:0], 4'h1)
        // ----------------------------------------
        // Command sequences
        // ----------------------------------------
        slow = 1;
        wr(4'h0, 8'h01);
        tick(3);
        wr(4'h0, 8'h00);
        `CHK(abt, 2'b01)
        `CHK(act, 2'b00)
        tick(1);
        `CHK(abt, 2'b00)
        slow = 0;
        wr(4'h0, 8'h09);
        `CHK(act, 2'b01)
        `CHK(dir, 2'b01)
        for (int k = 0; k < 20 && ints[0] !== 1'b1; k++) tick(1);
        `CHK(act, 2'b00)
        rd(4'h0, 32'h409);
        int_clr = 2'b01;
        tick(1);
        int_clr = 0;
        `CHK(ints, 2'b00)
        wr(4'h0, 8'h08);
        `CHK(abt, 2'b00)
        tick(1);
        wr(4'h8, 8'h09);
        `CHK(run, 2'b10)
        tick(1);
        wr(4'h8, 8'h00);
        `CHK(abt, 2'b10)
        busy = 2'b01;
        tick(1);
        wr(4'h0, 8'hF6);
        rd(4'h0, 32'h08);
        busy = 0;
        wr(4'h0, 8'hF6);
        rd(4'h0, 32'h00);
        wr(4'h4, 8'h01);
        rd(4'h4, 32'h00);
        `CHK(hit, 1'b1)
        // Next block up: offset 0 there must not reach the command register
        io_addr = BASE + 16'h0010;
        io_wr = 1;
        tick(1);
        io_wr = 0;
        `CHK(hit, 1'b0)
        `CHK(run, 2'b00)
        be = 4'hE;
        tick(1);
        wr(4'h0, 8'h01);
        `CHK(run, 2'b00)
        // Reset in mid-run while the primary channel is active
        be = 4'hF;
        tick(1);
        wr(4'h0, 8'h09);
        i_reset = 1;
        tick(1);
        i_reset = 0;
        `CHK(run, 2'b00)
        `CHK(dir, 2'b00)
        `CHK(act, 2'b00)
        `CHK(smp, 8'h55)
        `CHK(rcv, 8'h44)
        rd(4'h0, 32'h0);
        conclude();
    end

    // Whole run is well under 400 cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        bad_count++;
        conclude();
    end
endmodule : testbench

// >>> verilog/ibm_bus_master.sv
// Top: I/O block decode and both channels of the bus master command logic
`timescale 1ns/1ps
`include "ibm_params.svh"

module ibm_bus_master (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // I/O access
    input  wire logic [15:0] i_io_base,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [3:0]  i_io_be,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [31:0] i_io_wdata,
    output logic [31:0]      o_io_rdata,
    output logic             o_io_hit,
    // Per-channel status clear (bit 2 write-one)
    input  wire logic [1:0]  i_int_clear,
    // Transfer engine and drives, index 0 primary
    input  wire logic [1:0]  i_last_region_done,
    input  wire logic [1:0]  i_sync_dma_busy,
    input  wire logic [1:0]  i_drive_irq,
    input  wire logic [1:0]  i_drive_sel,
    input  wire logic [1:0]  i_dma_cycle,
    // Timing configuration
    input  wire logic [15:0] i_timing_word_pri,
    input  wire logic [15:0] i_timing_word_sec,
    input  wire logic [7:0]  i_slave_timing_byte,
    // Channel state
    output logic [1:0]       o_run,
    output logic [1:0]       o_dir,
    output logic [1:0]       o_active,
    output logic [1:0]       o_int_status,
    output logic [1:0]       o_abort,
    output logic [7:0]       o_sample,
    output logic [7:0]       o_recovery
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic        in_blk;
    logic [3:0]  ofs;
    logic [1:0]  cmd_we;
    logic [7:0]  cmd_q [2];
    logic [31:0] rdata_next;
    logic        hit_next;

    always_comb begin
        in_blk = (i_io_addr[15:4] == i_io_base[15:4]);
        ofs    = {i_io_addr[3:2], 2'b00};
        cmd_we = 2'b00;
        if (in_blk && i_io_wr && i_io_be[0] && ofs == `IBM_OFS_PRI_CMD) begin
            cmd_we[0] = 1'b1;
        end else if (in_blk && i_io_wr && i_io_be[0] && ofs == `IBM_OFS_SEC_CMD) begin
            cmd_we[1] = 1'b1;
        end
        rdata_next = 32'h0000_0000;
        hit_next   = in_blk && (i_io_rd || i_io_wr);
        if (in_blk && i_io_rd && ofs == `IBM_OFS_PRI_CMD) begin
            rdata_next = {16'h0000, 5'h00, o_int_status[0], 1'b0, o_active[0], cmd_q[0]};
        end else if (in_blk && i_io_rd && ofs == `IBM_OFS_SEC_CMD) begin
            rdata_next = {16'h0000, 5'h00, o_int_status[1], 1'b0, o_active[1], cmd_q[1]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_io_rdata <= 32'h0000_0000;
            o_io_hit   <= 1'b0;
        end else begin
            o_io_rdata <= rdata_next;
            o_io_hit   <= hit_next;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic [7:0] cmd_w;
            logic       act_w, int_w, abt_w;
            logic [3:0] smp_w, rec_w;
            ibm_channel u_chan (
                .i_clk              (i_clk),
                .i_reset            (i_reset),
                .i_cmd_we           (cmd_we[g]),
                .i_cmd_wdata        (i_io_wdata[7:0]),
                .i_stat_clr_int     (i_int_clear[g]),
                .i_last_region_done (i_last_region_done[g]),
                .i_sync_dma_busy    (i_sync_dma_busy[g]),
                .i_drive_irq        (i_drive_irq[g]),
                .i_drive_sel        (i_drive_sel[g]),
                .i_dma_cycle        (i_dma_cycle[g]),
                .i_timing_word      (g == 0 ? i_timing_word_pri : i_timing_word_sec),
                .i_slave_timing     (i_slave_timing_byte[g*4 +: 4]),
                .i_slave_sep_en     (g == 0 ? i_timing_word_pri[`IBM_TW_SEP_EN]
                                            : i_timing_word_sec[`IBM_TW_SEP_EN]),
                .o_cmd              (cmd_w),
                .o_active           (act_w),
                .o_int_status       (int_w),
                .o_abort            (abt_w),
                .o_sample           (smp_w),
                .o_recovery         (rec_w)
            );
            assign cmd_q[g]          = cmd_w;
            assign o_run[g]          = cmd_w[`IBM_BIT_RUN];
            assign o_dir[g]          = cmd_w[`IBM_BIT_DIR];
            assign o_active[g]       = act_w;
            assign o_int_status[g]   = int_w;
            assign o_abort[g]        = abt_w;
            assign o_sample[g*4 +: 4]   = smp_w;
            assign o_recovery[g*4 +: 4] = rec_w;
        end
    endgenerate
endmodule : ibm_bus_master

// >>> verilog/ibm_channel.sv
// One channel: command bits, activity, drive interrupt status, cycle timing
`timescale 1ns/1ps
`include "ibm_params.svh"

module ibm_channel (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Command register writes
    input  wire logic        i_cmd_we,
    input  wire logic [7:0]  i_cmd_wdata,
    input  wire logic        i_stat_clr_int,
    // Transfer engine and drive
    input  wire logic        i_last_region_done,
    input  wire logic        i_sync_dma_busy,
    input  wire logic        i_drive_irq,
    input  wire logic        i_drive_sel,
    input  wire logic        i_dma_cycle,
    input  wire logic [15:0] i_timing_word,
    input  wire logic [3:0]  i_slave_timing,
    input  wire logic        i_slave_sep_en,
    // State
    output logic [7:0]       o_cmd,
    output logic             o_active,
    output logic             o_int_status,
    output logic             o_abort,
    output logic [3:0]       o_sample,
    output logic [3:0]       o_recovery
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] cmd_reg, cmd_next;
    logic       int_reg, int_next;
    logic       irq_d_reg, irq_d_next;
    logic       abort_reg, abort_next;
    logic       act_reg, act_next;
    logic [3:0] smp_reg, smp_next, rec_reg, rec_next;
    ibm_pkg::ibm_chan_state_t st_reg, st_next;

    logic       use_slave, fast_ok;
    logic [3:0] isp_sel, rct_sel;

    always_comb begin
        cmd_next   = cmd_reg;
        st_next    = st_reg;
        abort_next = 1'b0;
        irq_d_next = i_drive_irq;
        int_next   = int_reg;
        if (i_stat_clr_int) begin
            int_next = 1'b0;
        end
        if (i_drive_irq && !irq_d_reg) begin
            int_next = 1'b1; // Set wins over clear
        end
        if (i_cmd_we) begin
            // Reserved bits stay zero
            cmd_next[`IBM_BIT_RUN] = i_cmd_wdata[`IBM_BIT_RUN];
            if (!i_sync_dma_busy) begin
                cmd_next[`IBM_BIT_DIR] = i_cmd_wdata[`IBM_BIT_DIR];
            end
        end
        case (st_reg)
            ibm_pkg::IBM_IDLE: begin
                if (i_cmd_we && i_cmd_wdata[`IBM_BIT_RUN]) begin
                    st_next = ibm_pkg::IBM_ACTIVE;
                end
            end
            ibm_pkg::IBM_ACTIVE: begin
                if (i_cmd_we && !i_cmd_wdata[`IBM_BIT_RUN]) begin
                    st_next    = ibm_pkg::IBM_IDLE; // Back to idle; interrupt status is kept, direction bit is taken from the write's bit 3 unless sync DMA is busy
                    abort_next = !int_reg;
                end else if (i_last_region_done) begin
                    st_next = ibm_pkg::IBM_DONE;
                end
            end
            ibm_pkg::IBM_DONE: begin
                // Restart needs a stop first, so no old operation resumes
                if (i_cmd_we && !i_cmd_wdata[`IBM_BIT_RUN]) begin
                    st_next = ibm_pkg::IBM_IDLE;
                end
            end
            default: begin
                st_next = ibm_pkg::IBM_IDLE;
            end
        endcase
        // Active kept in its own flop so the output needs no decode
        act_next = (st_next == ibm_pkg::IBM_ACTIVE);
    end

    // ----------------------------------------
    // Timing selection
    // ----------------------------------------
    always_comb begin
        use_slave = i_drive_sel && i_slave_sep_en;
        isp_sel   = use_slave ? {2'b00, i_slave_timing[`IBM_SLV_ISP_HI:`IBM_SLV_ISP_LO]}
                              : {2'b00, i_timing_word[`IBM_TW_ISP_HI:`IBM_TW_ISP_LO]};
        rct_sel   = use_slave ? {2'b00, i_slave_timing[`IBM_SLV_RCT_HI:`IBM_SLV_RCT_LO]}
                              : {2'b00, i_timing_word[`IBM_TW_RCT_HI:`IBM_TW_RCT_LO]};
        // Fast timing only on DMA data when the DMA-only option is set
        fast_ok   = !(i_drive_sel ? i_timing_word[`IBM_TW_DTE_D1]
                                  : i_timing_word[`IBM_TW_DTE_D0]) || i_dma_cycle;
        smp_next  = fast_ok ? (`IBM_COMPAT_SAMPLE - isp_sel) : `IBM_COMPAT_SAMPLE;
        rec_next  = fast_ok ? (`IBM_COMPAT_RECOVERY - rct_sel) : `IBM_COMPAT_RECOVERY;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmd_reg   <= `IBM_CMD_RESET;
            st_reg    <= ibm_pkg::IBM_IDLE;
            int_reg   <= 1'b0;
            irq_d_reg <= 1'b0;
            abort_reg <= 1'b0;
            act_reg   <= 1'b0;
            smp_reg   <= `IBM_COMPAT_SAMPLE;
            rec_reg   <= `IBM_COMPAT_RECOVERY;
        end else begin
            cmd_reg   <= cmd_next;
            st_reg    <= st_next;
            int_reg   <= int_next;
            irq_d_reg <= irq_d_next;
            abort_reg <= abort_next;
            act_reg   <= act_next;
            smp_reg   <= smp_next;
            rec_reg   <= rec_next;
        end
    end

    assign o_cmd        = cmd_reg;
    assign o_active     = act_reg;
    assign o_int_status = int_reg;
    assign o_abort      = abort_reg;
    assign o_sample     = smp_reg;
    assign o_recovery   = rec_reg;
endmodule : ibm_channel
